// ===== scp_pkg.sv
// Package with register map, field layout, timing counts and carriers of the config port
package scp_pkg;
  localparam int unsigned clk_hz = 50_000_000;
  localparam logic [7:0] soft_reset_ctrl_addr = 8'h00;
  localparam logic [7:0] power_down_ctrl_addr = 8'h0f;
  localparam logic [7:0] output_drive_ctrl_addr = 8'h11;
  localparam logic [7:0] output_termination_ctrl_addr = 8'h12;
  localparam int unsigned word_bits = 24;
  localparam int unsigned addr_msb = 23;
  localparam int unsigned addr_lsb = 16;
  localparam int unsigned soft_reset_pos = 0;
  localparam int unsigned channel_sleep_lsb = 0;
  localparam int unsigned partial_sleep_pos = 8;
  localparam int unsigned full_sleep_pos = 9;
  localparam int unsigned sleep_pin_select_pos = 10;
  localparam int unsigned bitclk_drive_lsb = 0;
  localparam int unsigned frameclk_drive_lsb = 4;
  localparam int unsigned dataout_drive_lsb = 8;
  localparam int unsigned term_enable_pos = 14;
  localparam int unsigned bitclk_term_lsb = 0;
  localparam logic [15:0] power_down_ctrl_rst = 16'h0000;
  localparam logic [15:0] output_drive_ctrl_rst = 16'h0000;
  localparam logic [15:0] output_termination_ctrl_rst = 16'h0000;
  // Wake times, printed in nanoseconds; both cycle counts round down
  localparam int unsigned full_wake_ns = 50_000;
  localparam int unsigned partial_wake_ns = 2_000;
  localparam int unsigned full_wake_cycles = full_wake_ns / (1_000_000_000 / clk_hz);
  localparam int unsigned partial_wake_cycles = partial_wake_ns / (1_000_000_000 / clk_hz);
  // Sync, edge and output stages eat into the wake budget, so the timer loads less
  localparam int unsigned wake_lag_cycles = 6;
  localparam int unsigned wake_cnt_w = 12;

  typedef struct packed {
    logic [7:0] channel_sleep_bits;
    logic partial_sleep;
    logic full_sleep;
    logic sleep_pin_select;
  } scp_power_s;

  typedef struct packed {
    logic [2:0] bitclk_drive_strength;
    logic [2:0] frameclk_drive_strength;
    logic [2:0] dataout_drive_strength;
    logic term_enable;
    logic [2:0] bitclk_term_setting;
  } scp_driver_s;
endpackage

// ===== scp_wake_timer.sv
// Wake timer: holds a busy flag for a loaded number of cycles after power-down ends
`timescale 1ns/1ps
module scp_wake_timer
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [scp_pkg::wake_cnt_w-1:0] load,
  output logic busy
);
  logic [scp_pkg::wake_cnt_w-1:0] cnt_q;

  assign busy = (cnt_q != '0);

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (start)
      cnt_q <= load;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
endmodule // scp_wake_timer

// ===== scp_serial_config.sv
// Serial configuration port: shifter, register file, power-down and wake control
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Bits are shifted in only while select is low.
// - Data line is sampled at each rising serial clock edge.
// - Every 24th rising edge writes the word to its register.
// - Trailing bits short of a full word change nothing.
// - Several words per select-low period each write their register.
// - Word is 8-bit address then 16-bit data.
// - Serial clock up to 20MHz, any slow rate, each clock phase at least one 20ns mclk cycle.
// - Low pulse on reset pin returns registers to defaults.
// - Soft-reset bit restores defaults and clears itself.
// - Partial sleep bit enters fast-recovery power-down, default off.
// - Full sleep bit enters slow-recovery power-down, default off.
// - Sleep pin select picks partial (set) or full (clear) for pin.
// - Wake from full power-down within 50us.
// - Wake from partial power-down within 2us.
// - Register 11 holds three 3-bit drive fields, default 3.5mA.
// - Bit 14 of register 11 enables internal termination.
// - Register 12 holds bit clock termination, host writes bit 14 one.
module scp_serial_config
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_input_line,
  input wire logic reset_pin_n,
  input wire logic sleep_pin,
  output scp_pkg::scp_power_s power_q,
  output scp_pkg::scp_driver_s driver_q,
  output logic partial_down_q,
  output logic full_down_q,
  output logic awake_q,
  output logic write_strobe_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by second
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sclk_prev_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // Idle pin levels, so no false serial edge follows reset
      meta_q <= 4'h9;
      sync_q <= 4'h9;
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {select_n, serial_clk, serial_input_line, reset_pin_n};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[2];
    end
  end

  wire sel_n_s = sync_q[3];
  wire sclk_s = sync_q[2];
  wire serial_input_line_s = sync_q[1];
  wire rstpin_n_s = sync_q[0];
  // Link at 20MHz max is seen at 50MHz only through the sync; faster links alias
  wire sclk_rise = sclk_s & ~sclk_prev_q;

  logic sleep_meta_q;
  logic sleep_sync_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sleep_meta_q <= 1'b0;
      sleep_sync_q <= 1'b0;
    end
    else
    begin
      sleep_meta_q <= sleep_pin;
      sleep_sync_q <= sleep_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shifter and bit counter
  logic [23:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  logic [23:0] shift_d;
  logic word_done;

  wire shift_en = ~sel_n_s & sclk_rise;
  assign word_done = shift_en & (bit_cnt_q == 5'(scp_pkg::word_bits - 1));
  assign shift_d = {shift_q[22:0], serial_input_line_s};
  assign bit_cnt_d = word_done ? 5'h00 : bit_cnt_q + 5'h01;

  always_ff @(posedge mclk)
  begin
    if (rst || sel_n_s)
    begin
      // Select high drops any partial word
      bit_cnt_q <= 5'h00;
      shift_q <= 24'h000000;
    end
    else if (shift_en)
    begin
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word decode
  wire [7:0] w_addr = shift_d[scp_pkg::addr_msb:scp_pkg::addr_lsb];
  wire [15:0] w_data = shift_d[15:0];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  wire wr_soft = word_done & hit(w_addr, scp_pkg::soft_reset_ctrl_addr);
  wire wr_pwr = word_done & hit(w_addr, scp_pkg::power_down_ctrl_addr);
  wire wr_drv = word_done & hit(w_addr, scp_pkg::output_drive_ctrl_addr);
  wire wr_term = word_done & hit(w_addr, scp_pkg::output_termination_ctrl_addr);
  // Soft reset pulse; nothing holds the bit, so it reads back clear
  wire soft_rst = wr_soft & w_data[scp_pkg::soft_reset_pos];
  wire cfg_rst = rst | ~rstpin_n_s | soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [15:0] pwr_reg_q;
  logic [15:0] drv_reg_q;
  logic [15:0] term_reg_q;

  always_ff @(posedge mclk)
  begin
    if (cfg_rst)
    begin
      pwr_reg_q <= scp_pkg::power_down_ctrl_rst;
      drv_reg_q <= scp_pkg::output_drive_ctrl_rst;
      term_reg_q <= scp_pkg::output_termination_ctrl_rst;
    end
    else
    begin
      if (wr_pwr)
        pwr_reg_q <= w_data;
      if (wr_drv)
        drv_reg_q <= w_data;
      if (wr_term)
        term_reg_q <= w_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down mode
  wire pin_partial = sleep_sync_q & pwr_reg_q[scp_pkg::sleep_pin_select_pos];
  wire pin_full = sleep_sync_q & ~pwr_reg_q[scp_pkg::sleep_pin_select_pos];
  wire full_d = pwr_reg_q[scp_pkg::full_sleep_pos] | pin_full;
  wire partial_d = ~full_d & (pwr_reg_q[scp_pkg::partial_sleep_pos] | pin_partial);

  wire leave_full = full_down_q & ~full_d;
  wire leave_part = partial_down_q & ~partial_d & ~full_d;
  wire [scp_pkg::wake_cnt_w-1:0] wake_load = leave_full ?
    scp_pkg::wake_cnt_w'(scp_pkg::full_wake_cycles - scp_pkg::wake_lag_cycles) :
    scp_pkg::wake_cnt_w'(scp_pkg::partial_wake_cycles - scp_pkg::wake_lag_cycles);
  logic wake_busy;

  scp_wake_timer u_wake
  (
    .mclk(mclk),
    .rst(rst),
    .start(leave_full | leave_part),
    .load(wake_load),
    .busy(wake_busy)
  );

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      full_down_q <= 1'b0;
      partial_down_q <= 1'b0;
      awake_q <= 1'b0;
      write_strobe_q <= 1'b0;
      power_q <= '0;
      driver_q <= '0;
    end
    else
    begin
      full_down_q <= full_d;
      partial_down_q <= partial_d;
      awake_q <= ~full_d & ~partial_d & ~wake_busy & ~leave_full & ~leave_part;
      write_strobe_q <= word_done;
      power_q <= '{channel_sleep_bits: pwr_reg_q[7:0],
                   partial_sleep: pwr_reg_q[scp_pkg::partial_sleep_pos],
                   full_sleep: pwr_reg_q[scp_pkg::full_sleep_pos],
                   sleep_pin_select: pwr_reg_q[scp_pkg::sleep_pin_select_pos]};
      driver_q <= '{bitclk_drive_strength: drv_reg_q[2:0],
                    frameclk_drive_strength: drv_reg_q[6:4],
                    dataout_drive_strength: drv_reg_q[10:8],
                    term_enable: drv_reg_q[scp_pkg::term_enable_pos],
                    bitclk_term_setting: term_reg_q[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [5:0] mark_cnt_q;
  always_ff @(posedge mclk)
  begin
    if (rst || sel_n_s)
      mark_cnt_q <= 6'h00;
    else if (shift_en)
      // Wraps at two words so long frames keep the modulo valid
      mark_cnt_q <= (mark_cnt_q == 6'd47) ? 6'h00 : mark_cnt_q + 6'h01;
  end

  a_no_shift_idle: assert property (@(posedge mclk) disable iff (rst)
    sel_n_s |=> (bit_cnt_q == 5'h00))
    else $error("bit count moved with select high");
  a_count_on_edge: assert property (@(posedge mclk) disable iff (rst)
    (shift_en && bit_cnt_q < 5'd23) |=> (bit_cnt_q == $past(bit_cnt_q) + 5'h01))
    else $error("bit not counted on serial edge");
  a_word_on_24: assert property (@(posedge mclk) disable iff (rst)
    word_done |-> (mark_cnt_q % 6'd24 == 6'd23))
    else $error("word written off the 24th edge");
  a_partial_drop: assert property (@(posedge mclk) disable iff (cfg_rst)
    (!word_done) |=> $stable(pwr_reg_q) && $stable(drv_reg_q) && $stable(term_reg_q))
    else $error("register changed without full word");
  a_pwr_write: assert property (@(posedge mclk) disable iff (cfg_rst)
    wr_pwr |=> (pwr_reg_q == $past(w_data)))
    else $error("power register not written");
  a_soft_clear: assert property (@(posedge mclk) disable iff (rst)
    soft_rst |=> (pwr_reg_q == scp_pkg::power_down_ctrl_rst) ##1 !soft_rst)
    else $error("soft reset did not clear registers");
  a_pin_reset: assert property (@(posedge mclk) disable iff (rst)
    !rstpin_n_s |=> (drv_reg_q == scp_pkg::output_drive_ctrl_rst))
    else $error("reset pin did not restore defaults");
  a_full_priority: assert property (@(posedge mclk) disable iff (rst)
    full_down_q |-> !partial_down_q)
    else $error("both power-down modes active");
  a_partial_wake: assert property (@(posedge mclk) disable iff (rst)
    (leave_part && !full_d) ##1 (!full_d && !partial_d)[*2] |-> ##[0:100] awake_q)
    else $error("partial wake too slow");
  c_two_words: cover property (@(posedge mclk) disable iff (rst)
    word_done ##[1:1000] word_done);
  c_soft_reset: cover property (@(posedge mclk) disable iff (rst) soft_rst);
  c_full_wake: cover property (@(posedge mclk) disable iff (rst) leave_full);
endmodule // scp_serial_config

// ===== scp_host_model.sv
// Host controller model for the three-wire configuration port
`timescale 1ns/1ps
module scp_host_model
(
  output logic select_n,
  output logic serial_clk,
  output logic serial_input_line
);
  initial
  begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_input_line = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shift n bits MSB first; frame low clocks with select held high
  task automatic shift(input int n, input logic [55:0] pat, input bit frame);
    #7;
    select_n = ~frame;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_input_line = pat[i];
      #80 serial_clk = 1'b1;
      #80 serial_clk = 1'b0;
    end
    #40;
    select_n = 1'b1;
    // Released line must not keep showing the last bit
    serial_input_line = ~serial_input_line;
    // Select stays high long enough for the sync to see it
    #40;
  endtask
  // Unused bits zero and one write per register are the caller's duty
  task automatic write(input logic [7:0] addr, input logic [15:0] data);
    shift(24, {32'h0, addr, data}, 1'b1);
  endtask
endmodule // scp_host_model

// ===== testbench.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic [7:0] addr;
    logic [15:0] data;
    scp_pkg::scp_power_s pwr;
    scp_pkg::scp_driver_s drv;
  } scp_row_s;
  logic mclk = 1'b0;
  logic rst, reset_pin_n, sleep_pin, select_n, serial_clk, serial_input_line;
  logic partial_down_q, full_down_q, awake_q, write_strobe_q;
  scp_pkg::scp_power_s power_q;
  scp_pkg::scp_driver_s driver_q;
  scp_row_s rows [5];
  int failures = 0;
  int cmp_count = 0;
  int strobes = 0;
  int cycles = 0;
  int s0, n;
  always #10 mclk = ~mclk;
  scp_serial_config u_dut (.mclk(mclk), .rst(rst), .select_n(select_n),
    .serial_clk(serial_clk), .serial_input_line(serial_input_line),
    .reset_pin_n(reset_pin_n), .sleep_pin(sleep_pin), .power_q(power_q),
    .driver_q(driver_q), .partial_down_q(partial_down_q), .full_down_q(full_down_q),
    .awake_q(awake_q), .write_strobe_q(write_strobe_q));
  scp_host_model u_host (.select_n(select_n), .serial_clk(serial_clk),
    .serial_input_line(serial_input_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic wake_wait;
    n = 0;
    while (awake_q !== 1'b1 && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic results;
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    strobes <= strobes + (write_strobe_q === 1'b1);
    cycles <= cycles + 1;
    // Whole run is near 5600 cycles
    if (cycles == 30000)
    begin
      failures++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{8'h0f, 16'h05a5, 11'h52d, 13'h0000}, '{8'h11, 16'h4765, 11'h52d, 13'h1778},
      '{8'h12, 16'h4003, 11'h52d, 13'h177b}, '{8'h33, 16'hffff, 11'h52d, 13'h177b},
      '{8'h0f, 16'h0200, 11'h002, 13'h177b}};
    rst = 1'b1;
    reset_pin_n = 1'b1;
    sleep_pin = 1'b0;
    tick(12);
    rst <= 1'b0;
    reset_pin_n <= 1'b0;
    tick(4);
    reset_pin_n <= 1'b1;
    tick(4);
    check(power_q, 0);
    check(driver_q, 0);
    for (int r = 0; r < 5; r++)
    begin
      u_host.write(rows[r].addr, rows[r].data);
      tick(6);
      check(power_q, rows[r].pwr);
      check(driver_q, rows[r].drv);
    end
    check(strobes, 5);
    check({full_down_q, awake_q}, 2'h2);
    u_host.write(8'h0f, 16'h0000);
    wake_wait();
    check(n < 2500, 1);
    s0 = strobes;
    u_host.shift(53, {3'h0, 8'h11, 16'h0001, 8'h12, 16'h4002, 5'h1f}, 1'b1);
    tick(6);
    check(driver_q, 13'h0402);
    check(strobes - s0, 2);
    u_host.shift(10, 56'h3ff, 1'b1);
    u_host.shift(24, {32'h0, 8'h11, 16'h0007}, 1'b0);
    u_host.write(8'h0f, 16'h0400);
    tick(6);
    check(power_q, 11'h001);
    check(driver_q, 13'h0402);
    check(strobes - s0, 3);
    sleep_pin <= 1'b1;
    tick(8);
    check({partial_down_q, full_down_q}, 2'h2);
    sleep_pin <= 1'b0;
    wake_wait();
    check(n < 100, 1);
    u_host.write(8'h0f, 16'h0000);
    sleep_pin <= 1'b1;
    tick(8);
    check({partial_down_q, full_down_q}, 2'h1);
    sleep_pin <= 1'b0;
    u_host.write(8'h11, 16'h4765);
    u_host.write(8'h00, 16'h0001);
    tick(6);
    check(driver_q, 0);
    u_host.write(8'h11, 16'h0001);
    tick(6);
    check(driver_q, 13'h0400);
    reset_pin_n <= 1'b0;
    tick(4);
    reset_pin_n <= 1'b1;
    tick(4);
    check(driver_q, 0);
    results();
  end
endmodule // testbench
